// *** verilog/wdt_pkg.sv ***
/*
 * constants, field positions and bus carrier type of the watchdog timer block.
 * assumes one 250 MHz system clock and a classic wishbone master with 32-bit data.
 */
package wdt_pkg;
   // register byte addresses
   localparam logic [31:0] ADDR_RELOAD     = 32'h4000_2580; // reload_value
   localparam logic [31:0] ADDR_COUNT      = 32'h4000_2584; // current_count
   localparam logic [31:0] ADDR_CTRL       = 32'h4000_2588; // watchdog_control
   localparam logic [31:0] ADDR_KICK       = 32'h4000_258C; // service_kick
   localparam logic [31:0] ADDR_STATE      = 32'h4000_2598; // watchdog_state
   localparam logic [31:0] ADDR_IRQ_STATUS = 32'h4000_25A0; // sticky events, write one clears
   localparam logic [31:0] ADDR_IRQ_MASK   = 32'h4000_25A4; // interrupt enables

   // reset values and special codes
   localparam logic [15:0] RELOAD_RST    = 16'h1000; // reload value after reset
   localparam logic [15:0] COUNT_RST     = 16'h1000; // live count after reset
   localparam logic [15:0] CTRL_RST      = 16'h00E9; // enabled, periodic, divide 256
   localparam logic [15:0] WRAP_VALUE    = 16'h1000; // free running wrap point
   localparam logic [15:0] SERVICE_CODE  = 16'hCCCC; // the only legal kick value
   localparam logic [15:0] CTRL_WR_MASK  = 16'h006F; // writable control bits
   localparam logic [15:0] CTRL_RSVD_VAL = 16'h0080; // reserved control bits as read
   localparam logic [1:0]  EVT_RST       = 2'h0;     // status and mask after reset

   // control field positions
   localparam int CTRL_MODE_BIT = 6; // 1 periodic, 0 free running
   localparam int CTRL_EN_BIT   = 5; // counter enable, also arms the lock
   localparam int CTRL_PRE_LO   = 2; // prescaler select, two bits
   localparam int CTRL_IRQ_BIT  = 1; // 1 interrupt on timeout, 0 reset
   localparam int CTRL_PMD_BIT  = 0; // suspend count in hibernate

   // watchdog_state and event field positions
   localparam int STATE_TMO_BIT = 0; // timeout interrupt pending
   localparam int STATE_LCK_BIT = 4; // configuration locked
   localparam int EVT_TMO_BIT   = 0; // timeout event
   localparam int EVT_SVC_BIT   = 1; // successful service event
   localparam int EVT_W         = 2; // number of event bits

   // timing: low frequency oscillator tick derived from the system clock
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
   localparam int unsigned LFOSC_HZ      = 32768;
   localparam int unsigned LFOSC_DIV     = CLK_HZ / LFOSC_HZ; // cycles per oscillator tick

   // prescaler division factors, indexed by the select field
   localparam logic [11:0] PRE_LIM0 = 12'h000; // divide by 1
   localparam logic [11:0] PRE_LIM1 = 12'h00F; // divide by 16
   localparam logic [11:0] PRE_LIM2 = 12'h0FF; // divide by 256
   localparam logic [11:0] PRE_LIM3 = 12'hFFF; // divide by 4096

   // one accepted bus request
   typedef struct packed {
      logic        we;    // write when high
      logic [31:0] addr;  // byte address
      logic [31:0] wdata; // write data
      logic [3:0]  sel;   // byte enables
   } bus_req_t;
endpackage

// *** verilog/wb_slave_port.sv ***
/*
 * classic wishbone slave front end: one request pulse per cycle, registered ack and data.
 * assumes the master holds its request until it sees ack and then drops stb.
 */
module wb_slave_port
   import wdt_pkg::*;
(
   input  wire logic        clk,       // system clock
   input  wire logic        reset_n,   // asynchronous reset, active low
   input  wire logic        wb_cyc_i,  // bus cycle
   input  wire logic        wb_stb_i,  // strobe
   input  wire logic        wb_we_i,   // write enable
   input  wire logic [31:0] wb_adr_i,  // byte address
   input  wire logic [31:0] wb_dat_i,  // write data
   input  wire logic [3:0]  wb_sel_i,  // byte enables
   input  wire logic [31:0] rd_data,   // read value for the current address
   output logic             wb_ack_o,  // acknowledge, one cycle
   output logic [31:0]      wb_dat_o,  // read data, valid with ack
   output wdt_pkg::bus_req_t req,      // current request fields
   output logic             req_valid  // request taken this cycle
);
   logic        ack_q; // ack register
   logic [31:0] dat_q; // read data register

   // a request is taken once, in the cycle before ack rises
   assign req_valid = wb_cyc_i & wb_stb_i & ~ack_q;
   assign req       = '{we: wb_we_i, addr: wb_adr_i, wdata: wb_dat_i, sel: wb_sel_i};

   // ack one cycle after the strobe, dropped in the next cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= req_valid;
         // writes return zero on the data lines
         dat_q <= (req_valid && !wb_we_i) ? rd_data : 32'h0000_0000;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
endmodule

// *** verilog/tick_divider.sv ***
/*
 * counter enable source: oscillator rate divider followed by a selectable prescaler.
 * assumes one clock; the tick is a one-cycle pulse on that clock.
 */
module tick_divider
   import wdt_pkg::*;
#(
   parameter int unsigned LF_DIV = wdt_pkg::LFOSC_DIV // system cycles per oscillator tick
) (
   input  wire logic       clk,     // system clock
   input  wire logic       reset_n, // asynchronous reset, active low
   input  wire logic       run,     // count while high, hold at zero while low
   input  wire logic [1:0] pre_sel, // prescaler select
   output logic            tick     // one-cycle count enable
);
   localparam int BW = (LF_DIV > 1) ? $clog2(LF_DIV) : 1;
   localparam logic [BW-1:0] BASE_LIM = BW'(LF_DIV - 1);

   logic [BW-1:0] base_q; // oscillator rate divider
   logic [11:0]   pre_q;  // prescaler counter
   logic          tick_q; // registered tick

   // decode of the prescaler select to the last count value
   function automatic logic [11:0] pre_limit(input logic [1:0] s);
      case (s)
         2'h0:    pre_limit = PRE_LIM0;
         2'h1:    pre_limit = PRE_LIM1;
         2'h2:    pre_limit = PRE_LIM2;
         default: pre_limit = PRE_LIM3;
      endcase
   endfunction

   // both counters restart from zero whenever counting stops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         base_q <= '0;
         pre_q  <= 12'h000;
         tick_q <= 1'b0;
      end else if (!run) begin
         base_q <= '0;
         pre_q  <= 12'h000;
         tick_q <= 1'b0;
      end else if (base_q == BASE_LIM) begin
         base_q <= '0;
         // one oscillator tick: advance the prescaler
         if (pre_q >= pre_limit(pre_sel)) begin
            pre_q  <= 12'h000;
            tick_q <= 1'b1;
         end else begin
            pre_q  <= pre_q + 12'h001;
            tick_q <= 1'b0;
         end
      end else begin
         base_q <= base_q + BW'(1);
         tick_q <= 1'b0;
      end
   end

   assign tick = tick_q;
endmodule

// *** verilog/watchdog_timer_regs.sv ***
/*
 * watchdog timer with its register set: reload, live count, control with lock,
 * service kick, state, sticky interrupt status and mask.
 * assumes a classic wishbone master, one 250 MHz clock and an asynchronous hibernate level.
 */
module watchdog_timer_regs
   import wdt_pkg::*;
#(
   parameter int unsigned LF_DIV = wdt_pkg::LFOSC_DIV // system cycles per oscillator tick
) (
   input  wire logic        clk,         // system clock, 250 MHz
   input  wire logic        reset_n,     // asynchronous reset, active low
   input  wire logic        wb_cyc_i,    // wishbone cycle
   input  wire logic        wb_stb_i,    // wishbone strobe
   input  wire logic        wb_we_i,     // wishbone write enable
   input  wire logic [31:0] wb_adr_i,    // wishbone byte address
   input  wire logic [31:0] wb_dat_i,    // wishbone write data
   input  wire logic [3:0]  wb_sel_i,    // wishbone byte enables
   input  wire logic        hibernate,   // hibernate level from power control, asynchronous
   output logic             wb_ack_o,    // wishbone acknowledge
   output logic [31:0]      wb_dat_o,    // wishbone read data
   output logic             irq,         // interrupt, level
   output logic             wdt_reset_o  // system reset request, one-cycle pulse
);
   bus_req_t          req;          // current bus request
   logic              req_valid;    // request taken this cycle
   logic [31:0]       rd_data;      // read mux output
   logic [15:0]       reload_q;     // reload value
   logic [15:0]       count_q;      // live down counter
   logic [15:0]       ctrl_q;       // writable control bits
   logic [15:0]       ctrl_view;    // control as software reads it
   logic              lock_q;       // configuration lock
   logic [EVT_W-1:0]  status_q;     // sticky events
   logic [EVT_W-1:0]  mask_q;       // interrupt enables
   logic [EVT_W-1:0]  evt_set;      // events this cycle
   logic [EVT_W-1:0]  evt_clr;      // clears this cycle
   logic              irq_q;        // interrupt register
   logic              rst_req_q;    // reset request register
   logic              hib_meta_q;   // hibernate synchroniser, first stage
   logic              hib_q;        // hibernate synchroniser, second stage
   logic              pre_tick;     // prescaled count enable
   logic              cnt_tick;     // count enable gated by enable bit
   logic              run;          // prescaler runs
   logic              wr;           // write taken this cycle
   logic              wr_reload;    // write to reload_value
   logic              wr_count;     // write to current_count
   logic              wr_ctrl;      // write to watchdog_control
   logic              wr_status;    // write to interrupt status
   logic              wr_mask;      // write to interrupt mask
   logic              kick;         // write to service_kick
   logic              good_kick;    // kick with the service code
   logic              bad_kick;     // kick with any other value
   logic              at_zero;      // counter passes zero this cycle
   logic              timeout_hit;  // timeout event
   logic [15:0]       wval;         // write data merged under byte enables
   logic [15:0]       ctrl_wval;    // control write data merged with the old value
   logic              ctrl_written_q; // a control write was taken since reset

   // merge low halfword write data with the old value under byte enables
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // bus front end
   wb_slave_port u_bus (
      .clk       (clk),
      .reset_n   (reset_n),
      .wb_cyc_i  (wb_cyc_i),
      .wb_stb_i  (wb_stb_i),
      .wb_we_i   (wb_we_i),
      .wb_adr_i  (wb_adr_i),
      .wb_dat_i  (wb_dat_i),
      .wb_sel_i  (wb_sel_i),
      .rd_data   (rd_data),
      .wb_ack_o  (wb_ack_o),
      .wb_dat_o  (wb_dat_o),
      .req       (req),
      .req_valid (req_valid)
   );

   // hibernate crosses in through two flip-flops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hib_meta_q <= 1'b0;
         hib_q      <= 1'b0;
      end else begin
         hib_meta_q <= hibernate;
         hib_q      <= hib_meta_q;
      end
   end

   // counting stops when disabled, or in hibernate with suspend selected
   assign run = ctrl_q[CTRL_EN_BIT] & ~(ctrl_q[CTRL_PMD_BIT] & hib_q);

   // oscillator and prescaler
   tick_divider #(
      .LF_DIV (LF_DIV)
   ) u_tick (
      .clk     (clk),
      .reset_n (reset_n),
      .run     (run),
      .pre_sel (ctrl_q[CTRL_PRE_LO +: 2]),
      .tick    (pre_tick)
   );

   // write decode
   assign wr        = req_valid & req.we;
   assign wval      = merge16(16'h0000, req.wdata, req.sel);
   assign ctrl_wval = merge16(ctrl_q, req.wdata, req.sel);
   assign wr_reload = wr && (req.addr == ADDR_RELOAD) && !lock_q;
   assign wr_count  = wr && (req.addr == ADDR_COUNT);
   assign wr_ctrl   = wr && (req.addr == ADDR_CTRL) && !lock_q;
   assign wr_status = wr && (req.addr == ADDR_IRQ_STATUS);
   assign wr_mask   = wr && (req.addr == ADDR_IRQ_MASK);
   assign kick      = wr && (req.addr == ADDR_KICK);
   assign good_kick = kick && (wval == SERVICE_CODE);
   assign bad_kick  = kick && (wval != SERVICE_CODE);

   // timeout when a count enable finds the counter at zero
   assign cnt_tick    = pre_tick & ctrl_q[CTRL_EN_BIT];
   assign at_zero     = cnt_tick && (count_q == 16'h0000);
   assign timeout_hit = at_zero && !good_kick;

   // reload value register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reload_q <= RELOAD_RST;
      end else if (wr_reload) begin
         reload_q <= merge16(reload_q, req.wdata, req.sel);
      end
   end

   // control register; reserved bits are never stored
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= CTRL_RST & CTRL_WR_MASK;
      end else if (wr_ctrl) begin
         ctrl_q <= ctrl_wval & CTRL_WR_MASK;
      end
   end

   // reserved bit 7 reads one, the other reserved bits zero
   assign ctrl_view = ctrl_q | CTRL_RSVD_VAL;

   // lock: a control write that leaves the enable bit set, cleared only by reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lock_q <= 1'b0;
      end else if (wr_ctrl && ctrl_wval[CTRL_EN_BIT]) begin
         lock_q <= 1'b1;
      end
   end

   // live down counter; bus writes to current_count are ignored
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q <= COUNT_RST;
      end else if (good_kick) begin
         count_q <= reload_q;
      end else if (at_zero) begin
         // periodic reloads, free running wraps to the fixed point
         if (ctrl_q[CTRL_MODE_BIT]) begin
            count_q <= reload_q;
         end else begin
            count_q <= WRAP_VALUE;
         end
      end else if (cnt_tick) begin
         count_q <= count_q - 16'h0001;
      end
   end

   // reset request: timeout outside interrupt mode, or a wrong kick
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_req_q <= 1'b0;
      end else begin
         rst_req_q <= bad_kick | (timeout_hit & ~ctrl_q[CTRL_IRQ_BIT]);
      end
   end

   // event sets and clears; a good kick also clears a pending timeout
   always_comb begin
      evt_set = '0;
      evt_clr = '0;
      evt_set[EVT_TMO_BIT] = timeout_hit & ctrl_q[CTRL_IRQ_BIT];
      evt_set[EVT_SVC_BIT] = good_kick;
      if (wr_status) begin
         evt_clr = wval[EVT_W-1:0];
      end
      if (good_kick) begin
         evt_clr[EVT_TMO_BIT] = 1'b1;
      end
   end

   // sticky status, a set in the clearing cycle wins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_q <= EVT_RST;
      end else begin
         status_q <= (status_q & ~evt_clr) | evt_set;
      end
   end

   // interrupt mask
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mask_q <= EVT_RST;
      end else if (wr_mask) begin
         mask_q <= wval[EVT_W-1:0];
      end
   end

   // interrupt output, high while an enabled event is pending
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & mask_q);
      end
   end

   // read mux; unmapped and write-only addresses read zero
   always_comb begin
      rd_data = 32'h0000_0000;
      case (req.addr)
         ADDR_RELOAD:     rd_data[15:0] = reload_q;
         ADDR_COUNT:      rd_data[15:0] = count_q;
         ADDR_CTRL:       rd_data[15:0] = ctrl_view;
         ADDR_STATE: begin
            rd_data[STATE_TMO_BIT] = status_q[EVT_TMO_BIT];
            rd_data[STATE_LCK_BIT] = lock_q;
         end
         ADDR_IRQ_STATUS: rd_data[EVT_W-1:0] = status_q;
         ADDR_IRQ_MASK:   rd_data[EVT_W-1:0] = mask_q;
         default:         rd_data = 32'h0000_0000;
      endcase
   end

   assign irq         = irq_q;
   assign wdt_reset_o = rst_req_q;

   // check helper: remembers whether software has touched the control register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_written_q <= 1'b0;
      end else if (wr_ctrl) begin
         ctrl_written_q <= 1'b1;
      end
   end

   // a kick with the service code, and one with anything else
   sequence s_good_kick;
      good_kick;
   endsequence
   sequence s_bad_kick;
      bad_kick;
   endsequence

   // good kick restarts from reload, bad kick requests reset for one cycle
   property p_kick_reload;
      @(posedge clk) disable iff (!reset_n)
      s_good_kick |=> (count_q == $past(reload_q));
   endproperty
   a_kick_reload: assert property (p_kick_reload) else $error("kick did not reload");

   property p_bad_kick_reset;
      @(posedge clk) disable iff (!reset_n)
      s_bad_kick |=> wdt_reset_o ##1 (!wdt_reset_o || $past(bad_kick) || $past(timeout_hit));
   endproperty
   a_bad_kick_reset: assert property (p_bad_kick_reset) else $error("bad kick no reset");

   property p_count_ro;
      @(posedge clk) disable iff (!reset_n)
      (wr_count && !cnt_tick && !good_kick) |=> $stable(count_q);
   endproperty
   a_count_ro: assert property (p_count_ro) else $error("count changed by write");

   property p_lock_ctrl;
      @(posedge clk) disable iff (!reset_n)
      (lock_q && wr && req.addr == ADDR_CTRL) |=> $stable(ctrl_q) && lock_q;
   endproperty
   a_lock_ctrl: assert property (p_lock_ctrl) else $error("locked control changed");

   property p_lock_reload;
      @(posedge clk) disable iff (!reset_n)
      (lock_q && wr && req.addr == ADDR_RELOAD) |=> $stable(reload_q);
   endproperty
   a_lock_reload: assert property (p_lock_reload) else $error("locked reload changed");

   property p_free_wrap;
      @(posedge clk) disable iff (!reset_n)
      (at_zero && !good_kick && !ctrl_q[CTRL_MODE_BIT]) |=> (count_q == 16'h1000);
   endproperty
   a_free_wrap: assert property (p_free_wrap) else $error("free running wrap wrong");

   property p_periodic_reload;
      @(posedge clk) disable iff (!reset_n)
      (at_zero && !good_kick && ctrl_q[CTRL_MODE_BIT]) |=> (count_q == $past(reload_q));
   endproperty
   a_periodic_reload: assert property (p_periodic_reload) else $error("no periodic reload");

   property p_disabled_hold;
      @(posedge clk) disable iff (!reset_n)
      (!ctrl_q[CTRL_EN_BIT] && !good_kick) |=> $stable(count_q);
   endproperty
   a_disabled_hold: assert property (p_disabled_hold) else $error("count moved disabled");

   property p_timeout_irq;
      @(posedge clk) disable iff (!reset_n)
      (timeout_hit && ctrl_q[CTRL_IRQ_BIT] && mask_q[EVT_TMO_BIT])
         |=> status_q[EVT_TMO_BIT] ##1 irq;
   endproperty
   a_timeout_irq: assert property (p_timeout_irq) else $error("timeout gave no irq");

   property p_timeout_reset;
      @(posedge clk) disable iff (!reset_n)
      (timeout_hit && !ctrl_q[CTRL_IRQ_BIT]) |=> wdt_reset_o;
   endproperty
   a_timeout_reset: assert property (p_timeout_reset) else $error("timeout gave no reset");

   property p_ctrl_reserved;
      @(posedge clk) disable iff (!reset_n)
      wr_ctrl |=> (ctrl_view[15:7] == 9'h001) && !ctrl_view[4];
   endproperty
   a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved bits wrong");

   // until software writes control, the watchdog runs enabled and periodic
   property p_mode_default;
      @(posedge clk) disable iff (!reset_n)
      !ctrl_written_q |-> (ctrl_view == CTRL_RST) && ctrl_q[CTRL_MODE_BIT]
         && ctrl_q[CTRL_EN_BIT];
   endproperty
   a_mode_default: assert property (p_mode_default) else $error("default mode wrong");

   // interrupt level follows the pending enabled events one cycle later
   property p_irq_level;
      @(posedge clk) disable iff (!reset_n)
      1'b1 |=> (irq == $past(|(status_q & mask_q)));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq level wrong");
endmodule

// *** testbench/tb_top.sv ***
/* self-checking bench for watchdog_timer_regs: reset values, lock, service, timeout, wrap.
 * assumes the wdt_pkg package and the one-cycle classic wishbone answer of the design. */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import wdt_pkg::*;
   localparam int unsigned DIV = 2; // short oscillator divide so timeouts come quickly
   typedef struct packed {
      logic        chk; // compare this answer
      logic [31:0] exp; // expected read data
   } note_t;
   logic        clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, hibernate;
   logic        wb_ack_o, irq, wdt_reset_o;
   logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd;
   logic [3:0]  wb_sel_i;
   logic [15:0] rv;            // random reload value
   note_t       notes[$];      // expected answers, oldest first
   int          fails, n_tests, n_rst, cycles, k;

   watchdog_timer_regs #(.LF_DIV(DIV)) u_watchdog_timer_regs (
      .clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
      .hibernate(hibernate), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .irq(irq),
      .wdt_reset_o(wdt_reset_o));

   // free running 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic stop_test();
      if (fails == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // watcher: takes the oldest note at each ack, counts reset pulses, cuts a hang short
   always @(posedge clk) begin : watch
      note_t n;
      cycles++;
      if (wdt_reset_o === 1'b1) n_rst++;
      if (wb_ack_o === 1'b1) begin
         n = notes.pop_front();
         if (n.chk === 1'b1) check(wb_dat_o, n.exp);
      end
      if (cycles >= 20000) begin
         fails++;
         stop_test();
      end
   end

   // one classic cycle: hold until ack is sampled, then release for a cycle
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic c, input logic [31:0] e);
      notes.push_back('{c, e});
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 1'b0, 32'h0);
   endtask

   task automatic rdc(input logic [31:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 1'b1, e);
   endtask

   // reset held for 16 cycles, then the pulse counter starts afresh
   task automatic go_reset();
      reset_n <= 1'b0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      n_rst = 0;
   endtask

   initial begin
      {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, hibernate} = 5'h0;
      {wb_adr_i, wb_dat_i, wb_sel_i} = 68'h0;
      {fails, n_tests, n_rst, cycles} = 0;
      void'($urandom(96));
      rv = 16'($urandom_range(9, 4));
      // reset values, read-only count, reserved control bits, lock in default state
      go_reset();
      rdc(ADDR_RELOAD, 32'(RELOAD_RST));
      rdc(ADDR_COUNT, 32'(COUNT_RST));
      rdc(ADDR_CTRL, 32'(CTRL_RST));
      wr(ADDR_COUNT, 32'h0000_0123);
      rdc(ADDR_COUNT, 32'(COUNT_RST));
      wr(ADDR_CTRL, 32'h0000_FF9F);
      rdc(ADDR_CTRL, 32'h0000_008F);
      rdc(ADDR_STATE, 32'h0);
      wr(ADDR_RELOAD, {16'h0, rv});
      rdc(ADDR_RELOAD, {16'h0, rv});
      rdc(32'h4000_25B0, 32'h0);
      rdc(ADDR_KICK, 32'h0);
      // enabling locks control and reload; timeout in reset mode
      wr(ADDR_CTRL, 32'h0000_0060);
      rdc(ADDR_CTRL, 32'h0000_00E0);
      rdc(ADDR_STATE, 32'h0000_0010);
      wr(ADDR_RELOAD, 32'h0000_0777);
      wr(ADDR_CTRL, 32'h0);
      rdc(ADDR_RELOAD, {16'h0, rv});
      rdc(ADDR_CTRL, 32'h0000_00E0);
      wr(ADDR_KICK, 32'h0000_CCCC);
      for (k = 0; k < 200 && n_rst == 0; k++) @(posedge clk);
      check(32'(n_rst > 0), 32'h1);
      // interrupt mode, periodic reload, wrong kick code
      go_reset();
      wr(ADDR_RELOAD, {16'h0, rv});
      wr(ADDR_IRQ_MASK, 32'h1);
      wr(ADDR_CTRL, 32'h0000_0062);
      wr(ADDR_KICK, 32'h0000_CCCC);
      for (k = 0; k < 200 && irq !== 1'b1; k++) @(posedge clk);
      check({31'h0, irq}, 32'h1);
      rdc(ADDR_IRQ_STATUS, 32'h3);
      wr(ADDR_IRQ_STATUS, 32'h2);
      rdc(ADDR_IRQ_STATUS, 32'h1);
      repeat (6) begin
         bus(1'b0, ADDR_COUNT, 32'h0, 1'b0, 32'h0);
         check(32'(rd[15:0] <= rv), 32'h1);
      end
      check(32'(n_rst), 32'h0);
      wr(ADDR_KICK, 32'h0000_1234);
      check(32'(n_rst), 32'h1);
      wr(ADDR_IRQ_MASK, 32'h0);
      @(posedge clk);
      check({31'h0, irq}, 32'h0);
      // free running: passing zero wraps to the fixed wrap point
      go_reset();
      wr(ADDR_RELOAD, {16'h0, rv});
      wr(ADDR_CTRL, 32'h0000_0022);
      wr(ADDR_KICK, 32'h0000_CCCC);
      rd = 32'h0;
      for (k = 0; k < 40 && rd[15:0] <= rv; k++) bus(1'b0, ADDR_COUNT, 32'h0, 1'b0, 32'h0);
      check(32'(rd[15:0] > 16'h0FF0 && rd[15:0] <= WRAP_VALUE), 32'h1);
      stop_test();
   end
endmodule
